// >>> src/sar_seq_pkg.sv
// Shared constants, states and switch bundle for the SAR conversion sequencer
package sar_seq_pkg;

  localparam int          RESULT_W      = 18;
  localparam logic [4:0]  BIT_COUNT     = 5'h12;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          ACQ_TIME_NS   = 250;
  // Least time, so round up to whole clock cycles
  localparam int          ACQ_CYC_INT   = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  ACQ_CYCLES    = ACQ_CYC_INT[7:0];
  localparam logic [7:0]  ACQ_CNT_RST   = 8'h00;

  localparam logic [17:0] SB_MIN        = 18'h00000;
  localparam logic [17:0] SB_MAX        = 18'h3FFFF;
  localparam logic [17:0] TC_MIN        = 18'h20000;
  localparam logic [17:0] TC_MAX        = 18'h1FFFF;
  localparam logic [17:0] MSB_ONLY      = 18'h20000;
  localparam logic [17:0] LSB_ONLY      = 18'h00001;
  localparam logic [17:0] RESULT_RST    = 18'h00000;

  typedef enum logic [2:0] {
    ST_ACQ    = 3'h0,
    ST_WAIT   = 3'h1,
    ST_OPEN   = 3'h2,
    ST_GROUND = 3'h3,
    ST_TRIAL  = 3'h4,
    ST_CODE   = 3'h5
  } seq_state_t;

  typedef struct packed {
    logic pos_sample;
    logic neg_sample;
    logic array_to_input;
    logic array_to_ground;
  } switch_ctrl_t;

  // Acquiring: sampling switches closed, arrays on the analog inputs
  localparam switch_ctrl_t SW_ACQUIRE = '{pos_sample: 1'b1, neg_sample: 1'b1,
                                          array_to_input: 1'b1, array_to_ground: 1'b0};
  localparam switch_ctrl_t SW_OPENED  = '{pos_sample: 1'b0, neg_sample: 1'b0,
                                          array_to_input: 1'b1, array_to_ground: 1'b0};
  localparam switch_ctrl_t SW_HELD    = '{pos_sample: 1'b0, neg_sample: 1'b0,
                                          array_to_input: 1'b0, array_to_ground: 1'b1};

endpackage

// >>> src/sar_bit_trial.sv
// Successive approximation register: one bit trial per clock, MSB first
`timescale 1ns/10ps
`default_nettype none
module sar_bit_trial (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic        input_above,
  output logic [17:0]      dac_code,
  output logic             last_trial
);

  logic [17:0] code_reg;
  logic [17:0] code_next;
  logic [17:0] probe_reg;
  logic [17:0] probe_next;

  always_comb begin
    code_next  = code_reg;
    probe_next = probe_reg;
    if (load) begin
      code_next  = sar_seq_pkg::MSB_ONLY;
      probe_next = sar_seq_pkg::MSB_ONLY;
    end else if (step && (probe_reg != '0)) begin
      // Keep the trial bit only if the input still sits above the DAC level
      code_next  = (input_above ? code_reg : (code_reg & ~probe_reg)) | (probe_reg >> 1);
      probe_next = probe_reg >> 1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      code_reg  <= sar_seq_pkg::RESULT_RST;
      probe_reg <= sar_seq_pkg::RESULT_RST;
    end else begin
      code_reg  <= code_next;
      probe_reg <= probe_next;
    end
  end

  assign dac_code   = code_reg;
  assign last_trial = (probe_reg == sar_seq_pkg::LSB_ONLY);

endmodule // sar_bit_trial
`default_nettype wire

// >>> src/sar_conversion_sequencer.sv
// Conversion sequencer: acquisition, hold, 18 bit trials, output coding
//
// Contract
// - Conversion starts only after acquisition ends and start input is low.
// - Sampled input freezes on the falling edge of the start input.
// - Open both sampling switches first, then move arrays from inputs to ground.
// - Resolve 18 bits by successive approximation, MSB first.
// - After the last trial form the code and drop busy.
// - Result belongs to the sample just taken; readable when busy falls.
// - Coding select picks binary or two's complement except in 18-bit parallel mode.
// - Straight binary: 00000 at -FS, 20000 at zero, 3FFFF at top.
// - Two's complement: 20000 at -FS, 00000 at zero, 1FFFF at top.
// - Over-range input saturates at 3FFFF binary or 1FFFF two's complement.
// - Under-range input saturates at 00000 binary or 20000 two's complement.
// - Start already low at acquisition end starts at once, else wait for edge.
// - Power-down high lets the current conversion finish, then blocks new ones.
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_sequencer (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       convert_start_n,
  input  wire logic                       power_down_input,
  input  wire logic                       output_coding_select,
  input  wire logic                       parallel_18_mode,
  input  wire logic                       comparator_above,
  input  wire logic                       over_range,
  input  wire logic                       under_range,
  output logic                            busy,
  output logic [17:0]                     result,
  output logic [17:0]                     dac_code,
  output sar_seq_pkg::switch_ctrl_t       switch_ctrl,
  output logic                            powered_down
);

  // Pin synchronisers: a level counts once the second and third stages agree
  logic [2:0] start_sync_reg;
  logic [2:0] pwdn_sync_reg;
  logic [2:0] coding_sync_reg;
  logic [2:0] mode_sync_reg;
  logic       start_level_reg;
  logic       start_level_next;
  logic       pwdn_level_reg;
  logic       pwdn_level_next;
  logic       coding_level_reg;
  logic       coding_level_next;
  logic       mode_level_reg;
  logic       mode_level_next;
  logic       start_fall;

  function automatic logic agreed(input logic [2:0] sync, input logic level);
    agreed = (sync[1] == sync[2]) ? sync[2] : level;
  endfunction

  always_comb begin
    start_level_next  = agreed(start_sync_reg, start_level_reg);
    pwdn_level_next   = agreed(pwdn_sync_reg, pwdn_level_reg);
    coding_level_next = agreed(coding_sync_reg, coding_level_reg);
    mode_level_next   = agreed(mode_sync_reg, mode_level_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_sync_reg   <= 3'h7;
      pwdn_sync_reg    <= 3'h0;
      coding_sync_reg  <= 3'h0;
      mode_sync_reg    <= 3'h0;
      start_level_reg  <= 1'b1;
      pwdn_level_reg   <= 1'b0;
      coding_level_reg <= 1'b0;
      mode_level_reg   <= 1'b0;
    end else begin
      start_sync_reg   <= {start_sync_reg[1:0], convert_start_n};
      pwdn_sync_reg    <= {pwdn_sync_reg[1:0], power_down_input};
      coding_sync_reg  <= {coding_sync_reg[1:0], output_coding_select};
      mode_sync_reg    <= {mode_sync_reg[1:0], parallel_18_mode};
      start_level_reg  <= start_level_next;
      pwdn_level_reg   <= pwdn_level_next;
      coding_level_reg <= coding_level_next;
      mode_level_reg   <= mode_level_next;
    end
  end

  // Acting on the agreed level, not the raw pin, so the start edge is glitch-safe
  assign start_fall = start_level_reg & ~start_level_next;

  // Sequencer state
  sar_seq_pkg::seq_state_t   state_reg;
  sar_seq_pkg::seq_state_t   state_next;
  logic [7:0]                acq_cnt_reg;
  logic [7:0]                acq_cnt_next;
  logic                      busy_reg;
  logic                      busy_next;
  logic [17:0]               result_reg;
  logic [17:0]               result_next;
  sar_seq_pkg::switch_ctrl_t sw_reg;
  sar_seq_pkg::switch_ctrl_t sw_next;
  logic                      pdn_reg;
  logic                      pdn_next;
  logic                      sar_load;
  logic                      sar_step;
  logic                      sar_last;
  logic [17:0]               sar_code;
  logic                      use_tc;
  logic [17:0]               formed_code;

  sar_bit_trial u_trial (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .load        (sar_load),
    .step        (sar_step),
    .input_above (comparator_above),
    .dac_code    (sar_code),
    .last_trial  (sar_last)
  );

  // The 18-bit parallel bus has no pin left for the select, so binary is forced there
  assign use_tc = coding_level_reg & ~mode_level_reg;

  always_comb begin
    if (over_range) begin
      formed_code = use_tc ? sar_seq_pkg::TC_MAX : sar_seq_pkg::SB_MAX;
    end else if (under_range) begin
      formed_code = use_tc ? sar_seq_pkg::TC_MIN : sar_seq_pkg::SB_MIN;
    end else if (use_tc) begin
      formed_code = {~sar_code[17], sar_code[16:0]};
    end else begin
      formed_code = sar_code;
    end
  end

  always_comb begin
    state_next   = state_reg;
    acq_cnt_next = acq_cnt_reg;
    busy_next    = busy_reg;
    result_next  = result_reg;
    sw_next      = sw_reg;
    sar_load     = 1'b0;
    sar_step     = 1'b0;
    pdn_next     = 1'b0;
    case (state_reg)
      sar_seq_pkg::ST_ACQ: begin
        sw_next = sar_seq_pkg::SW_ACQUIRE;
        if (acq_cnt_reg != '0) begin
          acq_cnt_next = acq_cnt_reg - 8'h01;
        end else if (!start_level_reg && !pwdn_level_reg) begin
          state_next = sar_seq_pkg::ST_OPEN;
          sw_next    = sar_seq_pkg::SW_OPENED;
          busy_next  = 1'b1;
        end else begin
          state_next = sar_seq_pkg::ST_WAIT;
        end
      end
      sar_seq_pkg::ST_WAIT: begin
        pdn_next = pwdn_level_reg;
        if (start_fall && !pwdn_level_reg) begin
          state_next = sar_seq_pkg::ST_OPEN;
          sw_next    = sar_seq_pkg::SW_OPENED;
          busy_next  = 1'b1;
        end
      end
      sar_seq_pkg::ST_OPEN: begin
        state_next = sar_seq_pkg::ST_GROUND;
        sw_next    = sar_seq_pkg::SW_HELD;
      end
      sar_seq_pkg::ST_GROUND: begin
        state_next = sar_seq_pkg::ST_TRIAL;
        sar_load   = 1'b1;
      end
      sar_seq_pkg::ST_TRIAL: begin
        sar_step = 1'b1;
        if (sar_last) begin
          state_next = sar_seq_pkg::ST_CODE;
        end
      end
      sar_seq_pkg::ST_CODE: begin
        // Power-down only ever blocks the next start, so this conversion completes
        result_next  = formed_code;
        busy_next    = 1'b0;
        state_next   = sar_seq_pkg::ST_ACQ;
        acq_cnt_next = sar_seq_pkg::ACQ_CYCLES - 8'h01;
        sw_next      = sar_seq_pkg::SW_ACQUIRE;
      end
      default: begin
        state_next = sar_seq_pkg::ST_ACQ;
        busy_next  = 1'b0;
        sw_next    = sar_seq_pkg::SW_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg   <= sar_seq_pkg::ST_ACQ;
      acq_cnt_reg <= sar_seq_pkg::ACQ_CNT_RST;
      busy_reg    <= 1'b0;
      result_reg  <= sar_seq_pkg::RESULT_RST;
      sw_reg      <= sar_seq_pkg::SW_ACQUIRE;
      pdn_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      acq_cnt_reg <= acq_cnt_next;
      busy_reg    <= busy_next;
      result_reg  <= result_next;
      sw_reg      <= sw_next;
      pdn_reg     <= pdn_next;
    end
  end

  assign busy         = busy_reg;
  assign result       = result_reg;
  assign dac_code     = sar_code;
  assign switch_ctrl  = sw_reg;
  assign powered_down = pdn_reg;

  // Helper: number of trial cycles in the current conversion
  logic [4:0] trial_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (srst || state_reg == sar_seq_pkg::ST_GROUND) begin
      trial_cnt_reg <= 5'h00;
    end else if (state_reg == sar_seq_pkg::ST_TRIAL) begin
      trial_cnt_reg <= trial_cnt_reg + 5'h01;
    end
  end

  property p_start_on_fall;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_WAIT && start_fall && !pwdn_level_reg)
      |=> (state_reg == sar_seq_pkg::ST_OPEN && !sw_reg.pos_sample && !sw_reg.neg_sample);
  endproperty
  a_start_on_fall: assert property (p_start_on_fall) else $error("no hold on start edge");
  property p_no_early_start;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_ACQ && acq_cnt_reg != '0) |=> !busy_reg;
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("start during acquisition");
  property p_low_at_end;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_ACQ && acq_cnt_reg == '0 && !start_level_reg && !pwdn_level_reg)
      |=> state_reg == sar_seq_pkg::ST_OPEN;
  endproperty
  a_low_at_end: assert property (p_low_at_end) else $error("low start not taken at once");
  property p_switch_order;
    @(posedge ref_clk) disable iff (srst)
    $rose(busy_reg) |-> (sw_reg == sar_seq_pkg::SW_OPENED) ##1 (sw_reg == sar_seq_pkg::SW_HELD);
  endproperty
  a_switch_order: assert property (p_switch_order) else $error("switch sequence wrong");
  localparam logic [4:0] BIT_COUNT_L = sar_seq_pkg::BIT_COUNT;
  property p_eighteen_trials;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_CODE) |-> trial_cnt_reg == BIT_COUNT_L;
  endproperty
  a_eighteen_trials: assert property (p_eighteen_trials) else $error("trial count not 18");
  property p_busy_through;
    @(posedge ref_clk) disable iff (srst)
    $rose(busy_reg) |-> busy_reg [*8];
  endproperty
  a_busy_through: assert property (p_busy_through) else $error("busy dropped early");
  property p_busy_falls;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_CODE) |=> !busy_reg && result_reg == $past(formed_code);
  endproperty
  a_busy_falls: assert property (p_busy_falls) else $error("result not fresh at busy fall");
  property p_binary_code;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_CODE && !over_range && !under_range && mode_level_reg)
      |=> result_reg == sar_code;
  endproperty
  a_binary_code: assert property (p_binary_code) else $error("18-bit mode not binary");
  property p_over_sat;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_CODE && over_range)
      |=> result_reg == ($past(use_tc) ? sar_seq_pkg::TC_MAX : sar_seq_pkg::SB_MAX);
  endproperty
  a_over_sat: assert property (p_over_sat) else $error("over-range not saturated");
  property p_under_sat;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_CODE && !over_range && under_range)
      |=> result_reg == ($past(use_tc) ? sar_seq_pkg::TC_MIN : sar_seq_pkg::SB_MIN);
  endproperty
  a_under_sat: assert property (p_under_sat) else $error("under-range not saturated");
  property p_power_down_blocks;
    @(posedge ref_clk) disable iff (srst)
    (state_reg == sar_seq_pkg::ST_WAIT && pwdn_level_reg) |=> !busy_reg;
  endproperty
  a_power_down_blocks: assert property (p_power_down_blocks) else $error("start in power-down");

  c_edge_start: cover property (@(posedge ref_clk) disable iff (srst)
    state_reg == sar_seq_pkg::ST_WAIT ##1 state_reg == sar_seq_pkg::ST_OPEN);
  c_tc_result: cover property (@(posedge ref_clk) disable iff (srst)
    state_reg == sar_seq_pkg::ST_CODE && use_tc);
  c_pwdn_wait: cover property (@(posedge ref_clk) disable iff (srst) pdn_reg);

endmodule // sar_conversion_sequencer
`default_nettype wire

// >>> tb/analog_front_model.sv
// Behavioural model of the sampled analog input and comparator
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
  input  wire logic                      ref_clk,
  input  wire logic [17:0]               dac_code,
  input  wire sar_seq_pkg::switch_ctrl_t switch_ctrl,
  input  wire logic [17:0]               sample_level,
  input  wire logic                      force_over,
  input  wire logic                      force_under,
  output logic                           comparator_above,
  output logic                           over_range,
  output logic                           under_range
);
  logic [17:0] held_level_reg;
  logic        held_over_reg;
  logic        held_under_reg;

  // Tracks while the sampling switches are closed, frozen once they open
  always_ff @(posedge ref_clk) begin
    if (switch_ctrl.pos_sample) begin
      held_level_reg <= sample_level;
      held_over_reg  <= force_over;
      held_under_reg <= force_under;
    end
  end

  assign comparator_above = (held_level_reg >= dac_code);
  assign over_range       = held_over_reg;
  assign under_range      = held_under_reg;
endmodule // analog_front_model
`default_nettype wire

// >>> tb/test_sar_conversion_sequencer.sv
// Self-checking bench for the SAR conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module test_sar_conversion_sequencer;
  logic                      ref_clk = 1'b0;
  logic                      srst = 1'b1;
  logic                      convert_start_n = 1'b1;
  logic                      power_down_input = 1'b0;
  logic                      output_coding_select = 1'b0;
  logic                      parallel_18_mode = 1'b0;
  logic [17:0]               sample_level = 18'h00000;
  logic                      force_over = 1'b0;
  logic                      force_under = 1'b0;
  logic                      comparator_above;
  logic                      over_range;
  logic                      under_range;
  logic                      busy;
  logic [17:0]               result;
  logic [17:0]               dac_code;
  sar_seq_pkg::switch_ctrl_t switch_ctrl;
  logic                      powered_down;
  int                        errors = 0;
  int                        comparisons = 0;
  logic [31:0]               seed = 32'hB9C3DF86;
  logic [17:0]               corner [7] = '{18'h00000, 18'h00001, 18'h1FFFF, 18'h20000,
                                            18'h20001, 18'h3FFFE, 18'h3FFFF};

  always #2.5 ref_clk = ~ref_clk;

  sar_conversion_sequencer sar_conversion_sequencer_inst (
    .ref_clk(ref_clk), .srst(srst), .convert_start_n(convert_start_n),
    .power_down_input(power_down_input), .output_coding_select(output_coding_select),
    .parallel_18_mode(parallel_18_mode), .comparator_above(comparator_above),
    .over_range(over_range), .under_range(under_range), .busy(busy), .result(result),
    .dac_code(dac_code), .switch_ctrl(switch_ctrl), .powered_down(powered_down));

  analog_front_model analog_front_model_inst (
    .ref_clk(ref_clk), .dac_code(dac_code), .switch_ctrl(switch_ctrl),
    .sample_level(sample_level), .force_over(force_over), .force_under(force_under),
    .comparator_above(comparator_above), .over_range(over_range),
    .under_range(under_range));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Clamp first, then two's complement is the binary code with its top bit inverted
  function automatic logic [17:0] expect_code(input logic [17:0] s, input logic ov,
                                              input logic un, input logic tc, input logic par);
    logic [17:0] c;
    c = ov ? sar_seq_pkg::SB_MAX : (un ? sar_seq_pkg::SB_MIN : s);
    if (tc && !par) c = c ^ sar_seq_pkg::MSB_ONLY;
    return c;
  endfunction

  task automatic results;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_busy(input logic lvl, input int limit, output int n);
    n = 0;
    while (busy !== lvl && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
    if (busy !== lvl) begin
      check({17'h0, busy}, {17'h0, lvl});
      results();
    end
  endtask

  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge ref_clk);
      seen = seen | busy;
    end
    check({17'h0, seen}, 18'h00000);
  endtask

  // One conversion; leaves the start pin low so callers can test what follows
  task automatic run_conv(input logic [17:0] s, input logic ov, input logic un,
                          input logic tc, input logic par, input logic pwdn_mid);
    int n;
    @(posedge ref_clk);
    sample_level         <= s;
    force_over           <= ov;
    force_under          <= un;
    output_coding_select <= tc;
    parallel_18_mode     <= par;
    repeat (5) @(posedge ref_clk);
    convert_start_n <= 1'b0;
    @(negedge ref_clk);
    wait_busy(1'b1, 10, n);
    check({14'h0, switch_ctrl}, {14'h0, sar_seq_pkg::SW_OPENED});
    @(negedge ref_clk);
    check({14'h0, switch_ctrl}, {14'h0, sar_seq_pkg::SW_HELD});
    @(negedge ref_clk);
    check(dac_code, sar_seq_pkg::MSB_ONLY);
    // Raised mid-conversion on a rising edge; the wait below counts from the same negedge
    if (pwdn_mid) begin
      @(posedge ref_clk);
      power_down_input <= 1'b1;
    end
    wait_busy(1'b0, 30, n);
    check(18'(n + 2), 18'h00015);
    check(result, expect_code(s, ov, un, tc, par));
    check({14'h0, switch_ctrl}, {14'h0, sar_seq_pkg::SW_ACQUIRE});
  endtask

  task automatic rest;
    @(posedge ref_clk);
    convert_start_n <= 1'b1;
    repeat (int'(sar_seq_pkg::ACQ_CYCLES) + 5) @(posedge ref_clk);
  endtask

  initial begin
    int n;
    logic [31:0] r;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check({17'h0, busy}, 18'h00000);
    check(result, sar_seq_pkg::RESULT_RST);
    check({14'h0, switch_ctrl}, {14'h0, sar_seq_pkg::SW_ACQUIRE});
    for (int tc = 0; tc < 2; tc++) begin
      for (int i = 0; i < 7; i++) begin
        run_conv(corner[i], 1'b0, 1'b0, tc[0], 1'b0, 1'b0);
        rest();
      end
      run_conv(18'h12345, 1'b1, 1'b0, tc[0], 1'b0, 1'b0);
      rest();
      run_conv(18'h12345, 1'b0, 1'b1, tc[0], 1'b0, 1'b0);
      rest();
      run_conv(18'h12345, 1'b1, 1'b1, tc[0], 1'b1, 1'b0);
      rest();
    end
    $display("test corner codes done");
    run_conv(18'h2A5A5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_busy(1'b1, int'(sar_seq_pkg::ACQ_CYCLES) + 10, n);
    check(18'(n >= int'(sar_seq_pkg::ACQ_CYCLES)), 18'h00001);
    wait_busy(1'b0, 30, n);
    check(result, 18'h2A5A5);
    @(posedge ref_clk);
    convert_start_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    convert_start_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    convert_start_n <= 1'b1;
    quiet(100);
    $display("test start timing done");
    run_conv(18'h0F0F0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    quiet(100);
    check({17'h0, powered_down}, 18'h00001);
    @(posedge ref_clk);
    power_down_input <= 1'b0;
    quiet(20);
    rest();
    run_conv(18'h30303, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rest();
    $display("test power down done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      r    = seed;
      seed = xs(seed);
      run_conv(r[17:0], seed[2:0] == 3'h0, seed[5:3] == 3'h0, seed[6], seed[7], 1'b0);
      rest();
    end
    $display("test random conversions done");
    results();
  end
endmodule // test_sar_conversion_sequencer
`default_nettype wire
